// ==== eci_top.sv ====
// External control I/O, frequency lock, gain and waveform store
//
// Function
// - Command inputs act only while external control is enabled.
// - Commands are recognised on falling edges of their inputs.
// - Power, output, limiter, busy status levels: 0 off/normal, 1 on/busy.
// - Limiter status is the OR of peak, average and power limiters.
// - Status outputs are always driven, never tri-stated.
// - Two sequence sync outputs and one trigger output are provided.
// - Freq-lock modes track a sync reference from 40 to 999.9 Hz.
// - No phase offset setting; only frequency is tracked.
// - Source select picks external sync signal or mains line.
// - In freq-lock modes, sync frequency above 1 kHz switches the output off.
// - Gain modes: output is input times gain, 0.1 steps, ranged.
// - Voltage controlled amplitude output clamps at range maximum DC.
// - Waveform store holds 16 waveforms of 4096 words.
// - Waveform words are 16-bit two's complement samples.
// - Samples above 32767 are stored as 32767.
// - Samples below -32767 are stored as -32767.
// - Waveform writes are refused while the output is on.
//
// Added by the designer: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`include "eci_defs.svh"
`default_nettype none

module eci_top #(
   parameter logic [21:0] P_PER_MIN = 22'(`ECI_PER_ACC_MIN),
   parameter logic [21:0] P_PER_MAX = 22'(`ECI_PER_ACC_MAX),
   parameter logic [21:0] P_PER_OFF = 22'(`ECI_PER_OFF)
) (
   input  wire logic              I_CLOCK,
   input  wire logic              I_SYS_RST,
   input  wire logic              I_CLK_EN,
   // Register port
   input  wire logic [7:0]        I_ADDR,
   input  wire logic [31:0]       I_WDATA,
   input  wire logic              I_WR,
   input  wire logic              I_RD,
   output logic      [31:0]       O_RDATA,
   // Command pins, active low edges
   input  wire logic [6:0]        I_CMD_N,
   output logic      [6:0]        O_CMD_PULSE,
   // Internal state to report
   input  wire logic              I_POWER_ON,
   input  wire logic              I_LIM_PEAK_POS,
   input  wire logic              I_LIM_PEAK_NEG,
   input  wire logic              I_LIM_AVG,
   input  wire logic              I_LIM_POWER,
   input  wire logic              I_BUSY,
   input  wire logic [1:0]        I_SEQ_SYNC,
   input  wire logic              I_SEQ_TRIG,
   // Status pins
   output logic                   O_POWER_STAT,
   output logic                   O_OUTPUT_STAT,
   output logic                   O_LIMIT_STAT,
   output logic                   O_BUSY_STAT,
   output logic      [1:0]        O_SEQ_SYNC,
   output logic                   O_TRIG,
   // Frequency lock
   input  wire logic              I_EXT_SYNC,
   input  wire logic              I_LINE_SYNC,
   output logic                   O_FREQ_LOCKED,
   output logic      [21:0]       O_LOCK_PERIOD,
   // Amplitude path
   input  wire logic signed [15:0] I_EXT_IN,
   input  wire logic signed [15:0] I_INT_SAMPLE,
   output logic signed [15:0]     O_AMP_OUT,
   // Waveform store port
   input  wire logic              I_WAVE_WR,
   input  wire logic              I_WAVE_RD,
   input  wire logic [3:0]        I_WAVE_SEL,
   input  wire logic [11:0]       I_WAVE_ADDR,
   input  wire logic signed [23:0] I_WAVE_DATA,
   output logic      [15:0]       O_WAVE_RDATA,
   output logic                   O_WAVE_REFUSED
);

   // ========================================================
   // Helpers
   function automatic logic [15:0] clip16(input logic signed [31:0] v);
      logic [15:0] r;
      r = v[15:0];
      if (v > `ECI_WAVE_MAX) begin
         r = 16'h7fff;
      end else if (v < `ECI_WAVE_MIN) begin
         r = 16'h8001;
      end
      return r;
   endfunction : clip16

   function automatic logic [12:0] gain_lim(input logic [12:0] g,
                                            input logic hi);
      logic [12:0] m;
      m = hi ? `ECI_GAIN_MAX_HI : `ECI_GAIN_MAX_LO;
      return (g > m) ? m : g;
   endfunction : gain_lim

   // ========================================================
   // State
   eci_pkg::eci_state_s st_q;
   eci_pkg::eci_state_s st_d;

   // Flop storage; far too large to sit in the state struct
   logic [15:0] wave_mem [0:65535];
   logic [15:0] wave_rd_q;

   logic              ref_now;
   logic              ref_rise;
   logic [21:0]       per_meas;
   logic              lock_mode;
   logic              gain_mode;
   logic              add_mode;
   logic              vca_mode;
   logic signed [31:0] prod;
   logic signed [31:0] scaled;
   logic signed [31:0] sum;
   logic [15:0]       max_dc;
   logic [6:0]        cmd_fall;
   logic              wave_ok;

   // ========================================================
   // Decode
   always_comb begin
      ref_now   = st_q.src ? I_LINE_SYNC : I_EXT_SYNC;
      ref_rise  = ref_now & ~st_q.ref_prev;
      per_meas  = st_q.per_cnt + 22'h000001;
      cmd_fall  = st_q.cmd_s3 & ~st_q.cmd_s2;
      lock_mode = 1'b0;
      gain_mode = 1'b0;
      add_mode  = 1'b0;
      vca_mode  = 1'b0;
      case (st_q.mode)
         eci_pkg::ECI_MODE_ACDC_EXTERNAL_GAIN,
         eci_pkg::ECI_MODE_AC_EXTERNAL_GAIN: begin
            gain_mode = 1'b1;
         end
         eci_pkg::ECI_MODE_ACDC_EXTERNAL_ADD,
         eci_pkg::ECI_MODE_AC_EXTERNAL_ADD: begin
            add_mode = 1'b1;
         end
         eci_pkg::ECI_MODE_ACDC_FREQ_LOCK,
         eci_pkg::ECI_MODE_AC_FREQ_LOCK: begin
            lock_mode = 1'b1;
         end
         eci_pkg::ECI_MODE_AC_VOLTAGE_CONTROLLED_AMPLITUDE: begin
            vca_mode = 1'b1;
         end
         default: begin
            lock_mode = 1'b0;
         end
      endcase
      prod   = 32'(I_EXT_IN) * $signed({19'h00000, st_q.gain});
      scaled = prod / `ECI_GAIN_DIV;
      sum    = scaled + 32'(I_INT_SAMPLE);
      max_dc = st_q.hi_rng ? `ECI_MAX_DC_HI : `ECI_MAX_DC_LO;
      wave_ok = I_WAVE_WR & ~st_q.out_on;
   end

   // ========================================================
   // Next state
   always_comb begin
      st_d = st_q;

      // Two flops before the edge detector; idle high like the pull-up
      st_d.cmd_s1 = I_CMD_N;
      st_d.cmd_s2 = st_q.cmd_s1;
      st_d.cmd_s3 = st_q.cmd_s2;
      st_d.cmd_pls = st_q.en ? cmd_fall : 7'h00;

      // Status levels mirror internal state every cycle
      st_d.pwr  = I_POWER_ON;
      st_d.lim  = I_LIM_PEAK_POS | I_LIM_PEAK_NEG |
                  I_LIM_AVG | I_LIM_POWER;
      st_d.busy = I_BUSY;
      st_d.seq_sync = I_SEQ_SYNC;
      st_d.trig     = I_SEQ_TRIG;

      // Software register writes
      if (I_WR) begin
         case (I_ADDR)
            `ECI_ADR_CTRL: begin
               st_d.en     = I_WDATA[`ECI_CTRL_EN];
               st_d.src    = I_WDATA[`ECI_CTRL_SRC];
               st_d.hi_rng = I_WDATA[`ECI_CTRL_HIRNG];
               st_d.mode   = eci_pkg::eci_mode_e'(
                  I_WDATA[`ECI_CTRL_MODE_HI:`ECI_CTRL_MODE_LO]);
               st_d.gain   = gain_lim(st_q.gain,
                                      I_WDATA[`ECI_CTRL_HIRNG]);
            end
            `ECI_ADR_GAIN: begin
               st_d.gain = gain_lim(I_WDATA[12:0], st_q.hi_rng);
            end
            `ECI_ADR_OUT: begin
               st_d.out_on = I_WDATA[`ECI_OUT_ON];
            end
            default: begin
               st_d.gain = st_d.gain;
            end
         endcase
      end

      // Pin commands: on, then off wins when both land together
      if (st_d.cmd_pls[1]) begin
         st_d.out_on = 1'b1;
      end
      if (st_d.cmd_pls[0]) begin
         st_d.out_on = 1'b0;
      end

      // Period measurement; first edge after a source change only arms
      st_d.ref_prev = ref_now;
      if (I_WR && I_ADDR == `ECI_ADR_CTRL &&
          I_WDATA[`ECI_CTRL_SRC] != st_q.src) begin
         st_d.ref_seen = 1'b0;
         st_d.per_cnt  = 22'h000000;
         st_d.locked   = 1'b0;
      end else if (ref_rise) begin
         st_d.ref_seen = 1'b1;
         st_d.per_cnt  = 22'h000000;
         if (st_q.ref_seen) begin
            st_d.period = per_meas;
            st_d.locked = (per_meas >= P_PER_MIN) &&
                          (per_meas <= P_PER_MAX);
            st_d.overf  = per_meas < P_PER_OFF;
         end
      end else if (st_q.per_cnt <= P_PER_MAX) begin
         st_d.per_cnt = per_meas;
      end else begin
         // Reference stopped: too slow to lock
         st_d.locked = 1'b0;
         st_d.overf  = 1'b0;
      end
      // Frequency only; phase is never adjusted
      if (lock_mode && st_d.overf) begin
         st_d.out_on = 1'b0;
      end

      // Amplitude path
      if (gain_mode) begin
         st_d.amp = clip16(scaled);
      end else if (add_mode) begin
         st_d.amp = clip16(sum);
      end else if (vca_mode) begin
         if (scaled > $signed({16'h0000, max_dc})) begin
            st_d.amp = max_dc;
         end else begin
            st_d.amp = clip16(scaled);
         end
      end else begin
         st_d.amp = I_INT_SAMPLE;
      end

      st_d.wave_refused = I_WAVE_WR & st_q.out_on;

      // Read data valid only in the cycle after the strobe
      st_d.rdata = 32'h00000000;
      if (I_RD) begin
         case (I_ADDR)
            `ECI_ADR_CTRL: begin
               st_d.rdata[`ECI_CTRL_EN]    = st_q.en;
               st_d.rdata[`ECI_CTRL_SRC]   = st_q.src;
               st_d.rdata[`ECI_CTRL_HIRNG] = st_q.hi_rng;
               st_d.rdata[`ECI_CTRL_MODE_HI:`ECI_CTRL_MODE_LO] = st_q.mode;
            end
            `ECI_ADR_GAIN: begin
               st_d.rdata[12:0] = st_q.gain;
            end
            `ECI_ADR_STAT: begin
               st_d.rdata[`ECI_ST_PWR]   = st_q.pwr;
               st_d.rdata[`ECI_ST_OUT]   = st_q.out_on;
               st_d.rdata[`ECI_ST_LIM]   = st_q.lim;
               st_d.rdata[`ECI_ST_BUSY]  = st_q.busy;
               st_d.rdata[`ECI_ST_LOCK]  = st_q.locked;
               st_d.rdata[`ECI_ST_OVERF] = st_q.overf;
            end
            `ECI_ADR_PERIOD: begin
               st_d.rdata[21:0] = st_q.period;
            end
            `ECI_ADR_OUT: begin
               st_d.rdata[`ECI_OUT_ON] = st_q.out_on;
            end
            default: begin
               st_d.rdata = 32'h00000000;
            end
         endcase
      end
   end

   // ========================================================
   // Registers
   always_ff @(posedge I_CLOCK) begin
      if (I_SYS_RST) begin
         st_q          <= '0;
         st_q.cmd_s1   <= 7'h7f;
         st_q.cmd_s2   <= 7'h7f;
         st_q.cmd_s3   <= 7'h7f;
         st_q.mode     <= eci_pkg::eci_mode_e'(`ECI_RST_MODE);
         st_q.gain     <= `ECI_GAIN_DEF_LO;
      end else if (I_CLK_EN) begin
         st_q <= st_d;
      end
   end

   // Store writes only with the output off
   always_ff @(posedge I_CLOCK) begin
      if (I_CLK_EN && wave_ok) begin
         wave_mem[{I_WAVE_SEL, I_WAVE_ADDR}] <=
            clip16(32'(I_WAVE_DATA));
      end
   end

   always_ff @(posedge I_CLOCK) begin
      if (I_SYS_RST) begin
         wave_rd_q <= 16'h0000;
      end else if (I_CLK_EN && I_WAVE_RD) begin
         wave_rd_q <= wave_mem[{I_WAVE_SEL, I_WAVE_ADDR}];
      end
   end

   // ========================================================
   // Outputs, always driven
   assign O_RDATA        = st_q.rdata;
   assign O_CMD_PULSE    = st_q.cmd_pls;
   assign O_POWER_STAT   = st_q.pwr;
   assign O_OUTPUT_STAT  = st_q.out_on;
   assign O_LIMIT_STAT   = st_q.lim;
   assign O_BUSY_STAT    = st_q.busy;
   assign O_SEQ_SYNC     = st_q.seq_sync;
   assign O_TRIG         = st_q.trig;
   assign O_FREQ_LOCKED  = st_q.locked & lock_mode;
   assign O_LOCK_PERIOD  = st_q.period;
   assign O_AMP_OUT      = st_q.amp;
   assign O_WAVE_RDATA   = wave_rd_q;
   assign O_WAVE_REFUSED = st_q.wave_refused;

endmodule : eci_top
`default_nettype wire

// ==== eci_defs.svh ====
// Constants of the external control interface block
`ifndef ECI_DEFS_SVH
`define ECI_DEFS_SVH

// ==========================================================
// Register offsets
`define ECI_ADR_CTRL     8'h00
`define ECI_ADR_GAIN     8'h04
`define ECI_ADR_STAT     8'h08
`define ECI_ADR_PERIOD   8'h0c
`define ECI_ADR_OUT      8'h10

// ==========================================================
// Control fields
`define ECI_CTRL_EN      0
`define ECI_CTRL_SRC     1
`define ECI_CTRL_HIRNG   2
`define ECI_CTRL_MODE_LO 4
`define ECI_CTRL_MODE_HI 6
`define ECI_OUT_ON       0

// ==========================================================
// Status fields
`define ECI_ST_PWR       0
`define ECI_ST_OUT       1
`define ECI_ST_LIM       2
`define ECI_ST_BUSY      3
`define ECI_ST_LOCK      4
`define ECI_ST_OVERF     5

// ==========================================================
// Reset values and limits
`define ECI_RST_MODE     3'h0
`define ECI_GAIN_DEF_LO  13'h03e8
`define ECI_GAIN_DEF_HI  13'h07d0
`define ECI_GAIN_MAX_LO  13'h0b22
`define ECI_GAIN_MAX_HI  13'h1644
`define ECI_GAIN_DIV     10
`define ECI_MAX_DC_LO    16'h3fff
`define ECI_MAX_DC_HI    16'h7fff
`define ECI_WAVE_MAX     32767
`define ECI_WAVE_MIN     -32767

// ==========================================================
// Timing, clock in hertz, sync frequencies in tenths of a hertz
`define ECI_CLK_HZ       100000000
`define ECI_F_ACC_LO_DHZ 400
`define ECI_F_ACC_HI_DHZ 9999
`define ECI_F_OFF_DHZ    10000
`define ECI_PER_ACC_MAX  ((`ECI_CLK_HZ * 10) / `ECI_F_ACC_LO_DHZ)
`define ECI_PER_ACC_MIN  ((`ECI_CLK_HZ * 10 + `ECI_F_ACC_HI_DHZ - 1) \
                          / `ECI_F_ACC_HI_DHZ)
`define ECI_PER_OFF      ((`ECI_CLK_HZ * 10) / `ECI_F_OFF_DHZ)

`endif

// ==== eci_pkg.sv ====
// Types of the external control interface block
`default_nettype none
package eci_pkg;

   // =======================================================
   // Output modes
   typedef enum logic [2:0] {
      ECI_MODE_INTERNAL,
      ECI_MODE_ACDC_EXTERNAL_GAIN,
      ECI_MODE_AC_EXTERNAL_GAIN,
      ECI_MODE_ACDC_EXTERNAL_ADD,
      ECI_MODE_AC_EXTERNAL_ADD,
      ECI_MODE_ACDC_FREQ_LOCK,
      ECI_MODE_AC_FREQ_LOCK,
      ECI_MODE_AC_VOLTAGE_CONTROLLED_AMPLITUDE
   } eci_mode_e;

   // =======================================================
   // Block state apart from the waveform store and its read data register
   typedef struct packed {
      logic [6:0]        cmd_s1;
      logic [6:0]        cmd_s2;
      logic [6:0]        cmd_s3;
      logic [6:0]        cmd_pls;
      logic              en;
      logic              src;
      logic              hi_rng;
      eci_mode_e         mode;
      logic [12:0]       gain;
      logic              out_on;
      logic              pwr;
      logic              lim;
      logic              busy;
      logic [1:0]        seq_sync;
      logic              trig;
      logic              ref_prev;
      logic              ref_seen;
      logic [21:0]       per_cnt;
      logic [21:0]       period;
      logic              locked;
      logic              overf;
      logic signed [15:0] amp;
      logic [31:0]       rdata;
      logic              wave_refused;
   } eci_state_s;

endpackage : eci_pkg
`default_nettype wire

// ==== eci_ctl_model.sv ====
// External controller model driving the command pins
`timescale 1ns/1ps
`default_nettype none

module eci_ctl_model (
   input  wire logic       i_clk,
   output logic      [6:0] o_cmd_n
);
   // ==========
   // Pins rest high, as the pull-ups leave them
   initial o_cmd_n = 7'h7f;

   // One command: high to low, held a while, then high again
   task automatic fall(input int b, input int hold);
      @(posedge i_clk);
      o_cmd_n[b] <= 1'b0;
      repeat (hold) @(posedge i_clk);
      o_cmd_n[b] <= 1'b1;
   endtask : fall
endmodule : eci_ctl_model
`default_nettype wire

// ==== eci_top_properties.sv ====
// Port checker of the external control block
`timescale 1ns/1ps
`default_nettype none

module eci_chk #(
   parameter logic [21:0] P_PER_MIN = 22'd11,
   parameter logic [21:0] P_PER_MAX = 22'd250,
   parameter logic [21:0] P_PER_OFF = 22'd10
) (
   input wire logic        I_CLOCK,
   input wire logic        I_SYS_RST,
   input wire logic        I_RD,
   input wire logic [6:0]  I_CMD_N,
   input wire logic [6:0]  O_CMD_PULSE,
   input wire logic        I_POWER_ON,
   input wire logic        I_LIM_PEAK_POS,
   input wire logic        I_LIM_PEAK_NEG,
   input wire logic        I_LIM_AVG,
   input wire logic        I_LIM_POWER,
   input wire logic        I_BUSY,
   input wire logic [1:0]  I_SEQ_SYNC,
   input wire logic        I_SEQ_TRIG,
   input wire logic        O_POWER_STAT,
   input wire logic        O_OUTPUT_STAT,
   input wire logic        O_LIMIT_STAT,
   input wire logic        O_BUSY_STAT,
   input wire logic [1:0]  O_SEQ_SYNC,
   input wire logic        O_TRIG,
   input wire logic        O_FREQ_LOCKED,
   input wire logic [21:0] O_LOCK_PERIOD,
   input wire logic [31:0] O_RDATA,
   input wire logic        I_WAVE_WR,
   input wire logic        O_WAVE_REFUSED,
   input wire logic [15:0] O_WAVE_RDATA
);
   default clocking cb @(posedge I_CLOCK); endclocking
   default disable iff (I_SYS_RST);

   // ==========
   // Status pins
   chk_limit_or:
      assert property (!$past(I_SYS_RST) |-> O_LIMIT_STAT == $past(
         I_LIM_PEAK_POS | I_LIM_PEAK_NEG | I_LIM_AVG | I_LIM_POWER))
      else $error("limiter status is not the OR of the limiters");
   chk_status_copy:
      assert property (!$past(I_SYS_RST) |->
         {O_POWER_STAT, O_BUSY_STAT, O_SEQ_SYNC, O_TRIG} ==
         $past({I_POWER_ON, I_BUSY, I_SEQ_SYNC, I_SEQ_TRIG}))
      else $error("status pins do not follow their sources");

   // ==========
   // Commands; latency hedged by one cycle, polarity is exact
   chk_cmd_edge:
      assert property ((O_CMD_PULSE &
         ~(($past(I_CMD_N, 5) & ~$past(I_CMD_N, 4)) |
           ($past(I_CMD_N, 4) & ~$past(I_CMD_N, 3)))) == 7'h00)
      else $error("command pulse without a falling edge");
   chk_pulse_single:
      assert property (|O_CMD_PULSE |=>
         (O_CMD_PULSE & $past(O_CMD_PULSE)) == 7'h00)
      else $error("command pulse longer than one cycle");
   chk_off_wins:
      assert property (O_CMD_PULSE[0] |-> !O_OUTPUT_STAT)
      else $error("output still on after off command");

   // ==========
   // Lock, bus, store
   chk_lock_range:
      assert property (O_FREQ_LOCKED |->
         O_LOCK_PERIOD >= P_PER_MIN && O_LOCK_PERIOD <= P_PER_MAX)
      else $error("locked with period out of range");
   chk_rdata_idle:
      assert property (!$past(I_RD) |-> O_RDATA == 32'h0)
      else $error("read data outside its cycle");
   chk_refuse_pulse:
      assert property (!$past(I_SYS_RST) |->
         O_WAVE_REFUSED == $past(I_WAVE_WR & O_OUTPUT_STAT))
      else $error("refusal does not match write with output on");
   chk_wave_clip:
      assert property (O_WAVE_RDATA != 16'h8000)
      else $error("most negative sample read from store");

   cover property (O_CMD_PULSE[1]);
   cover property (O_WAVE_REFUSED);
   cover property (O_FREQ_LOCKED);
   cover property (O_LIMIT_STAT);
endmodule : eci_chk

bind eci_top eci_chk #(.P_PER_MIN(P_PER_MIN), .P_PER_MAX(P_PER_MAX),
   .P_PER_OFF(P_PER_OFF)) u_chk (.I_CLOCK(I_CLOCK), .I_SYS_RST(I_SYS_RST),
   .I_RD(I_RD), .I_CMD_N(I_CMD_N), .O_CMD_PULSE(O_CMD_PULSE),
   .I_POWER_ON(I_POWER_ON), .I_LIM_PEAK_POS(I_LIM_PEAK_POS),
   .I_LIM_PEAK_NEG(I_LIM_PEAK_NEG), .I_LIM_AVG(I_LIM_AVG),
   .I_LIM_POWER(I_LIM_POWER), .I_BUSY(I_BUSY), .I_SEQ_SYNC(I_SEQ_SYNC),
   .I_SEQ_TRIG(I_SEQ_TRIG), .O_POWER_STAT(O_POWER_STAT),
   .O_OUTPUT_STAT(O_OUTPUT_STAT), .O_LIMIT_STAT(O_LIMIT_STAT),
   .O_BUSY_STAT(O_BUSY_STAT), .O_SEQ_SYNC(O_SEQ_SYNC), .O_TRIG(O_TRIG),
   .O_FREQ_LOCKED(O_FREQ_LOCKED), .O_LOCK_PERIOD(O_LOCK_PERIOD),
   .O_RDATA(O_RDATA), .I_WAVE_WR(I_WAVE_WR),
   .O_WAVE_REFUSED(O_WAVE_REFUSED), .O_WAVE_RDATA(O_WAVE_RDATA));
`default_nettype wire

// ==== tb_external_control_io.sv ====
// Self-checking bench of the external control block
`timescale 1ns/1ps
`default_nettype none

module tb_external_control_io;
   logic               clk = 1'b0;
   logic               rst = 1'b1;
   logic [7:0]         addr = 8'h00;
   logic [31:0]        wdata = 32'h0;
   logic               wr = 1'b0;
   logic               rd = 1'b0;
   logic [31:0]        rdata;
   logic [6:0]         cmd_n;
   logic [6:0]         pulse;
   logic [5:0]         st_in = 6'h00;
   logic [2:0]         seq_in = 3'h0;
   logic               pwr_o, out_o, lim_o, busy_o, trg_o, locked, w_ref;
   logic [1:0]         sync_o;
   logic               ext_s = 1'b0;
   logic               line_s = 1'b0;
   logic [21:0]        per;
   logic signed [15:0] ext_in = 16'sh0;
   logic signed [15:0] int_in = 16'sh0;
   logic signed [15:0] amp;
   logic               w_wr = 1'b0;
   logic               w_rd = 1'b0;
   logic [3:0]         w_sel = 4'h0;
   logic [11:0]        w_adr = 12'h000;
   logic [23:0]        w_dat = 24'h0;
   logic [15:0]        w_q;
   logic [31:0]        seed = 32'h0000e388;
   logic               ce = 1'b1;
   logic [23:0]        cor [4] = '{24'h008000, 24'hff8000, 24'hff8001,
                                   24'h7fffff};
   int                 ns [3] = '{20, 300, 8};
   int                 miscompares = 0;
   int                 num_checks = 0;

   always #5 clk = ~clk;

   eci_top #(.P_PER_MIN(22'd11), .P_PER_MAX(22'd250), .P_PER_OFF(22'd10))
   uut (.I_CLOCK(clk), .I_SYS_RST(rst), .I_CLK_EN(ce), .I_ADDR(addr),
      .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata),
      .I_CMD_N(cmd_n), .O_CMD_PULSE(pulse), .I_POWER_ON(st_in[5]),
      .I_LIM_PEAK_POS(st_in[4]), .I_LIM_PEAK_NEG(st_in[3]),
      .I_LIM_AVG(st_in[2]), .I_LIM_POWER(st_in[1]), .I_BUSY(st_in[0]),
      .I_SEQ_SYNC(seq_in[2:1]), .I_SEQ_TRIG(seq_in[0]),
      .O_POWER_STAT(pwr_o), .O_OUTPUT_STAT(out_o), .O_LIMIT_STAT(lim_o),
      .O_BUSY_STAT(busy_o), .O_SEQ_SYNC(sync_o), .O_TRIG(trg_o),
      .I_EXT_SYNC(ext_s), .I_LINE_SYNC(line_s), .O_FREQ_LOCKED(locked),
      .O_LOCK_PERIOD(per), .I_EXT_IN(ext_in), .I_INT_SAMPLE(int_in),
      .O_AMP_OUT(amp), .I_WAVE_WR(w_wr), .I_WAVE_RD(w_rd),
      .I_WAVE_SEL(w_sel), .I_WAVE_ADDR(w_adr), .I_WAVE_DATA(w_dat),
      .O_WAVE_RDATA(w_q), .O_WAVE_REFUSED(w_ref));

   eci_ctl_model ctl (.i_clk(clk), .o_cmd_n(cmd_n));

   // ==========
   // Expectations
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd

   function automatic int f_amp(int m, int x, int s, int g, bit hi);
      int v;
      v = x * g / 10;
      if (m == 7 && v > (hi ? 32767 : 16383)) v = hi ? 32767 : 16383;
      if (m == 3 || m == 4) v = v + s;
      if (m == 0 || m == 5 || m == 6) return s;
      return v > 32767 ? 32767 : v < -32767 ? -32767 : v;
   endfunction : f_amp

   function automatic logic [15:0] f_clip(logic signed [23:0] d);
      return d > 32767 ? 16'h7fff : d < -32767 ? 16'h8001 : d[15:0];
   endfunction : f_clip

   // ==========
   // Drivers and compare
   task automatic chk(string n, logic [31:0] e, logic [31:0] s);
      num_checks++;
      if (s !== e) begin
         miscompares++;
         $display("BAD %s exp %h got %h", n, e, s);
      end
   endtask : chk

   task automatic wr_reg(logic [7:0] a, logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wr_reg

   task automatic rd_chk(string n, logic [7:0] a, logic [31:0] e);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 chk(n, e, rdata);
   endtask : rd_chk

   task automatic wave(bit w, logic [3:0] s, logic [11:0] a, logic [23:0] d);
      @(posedge clk);
      w_sel <= s;
      w_adr <= a;
      w_dat <= d;
      w_wr <= w;
      w_rd <= !w;
      @(posedge clk);
      w_wr <= 1'b0;
      w_rd <= 1'b0;
      #1;
   endtask : wave

   // Fall on pin j, count cycles in which bit j alone pulses
   task automatic cmd(int j, int e, int h);
      int c;
      c = 0;
      fork
         ctl.fall(j, h);
         repeat (10) begin
            @(posedge clk);
            #1 c += int'(pulse === 7'(1 << j));
         end
      join
      chk("pulses", 32'(e), 32'(c));
   endtask : cmd

   // Three rising edges spaced n cycles on the chosen reference
   task automatic rises(bit ln, int n);
      repeat (3) begin
         @(posedge clk);
         if (ln) line_s <= 1'b1;
         else ext_s <= 1'b1;
         @(posedge clk);
         line_s <= 1'b0;
         ext_s <= 1'b0;
         repeat (n - 2) @(posedge clk);
      end
      repeat (2) @(posedge clk);
      #1;
   endtask : rises

   task automatic conclude();
      if (miscompares == 0 && num_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : conclude

   initial begin
      repeat (20000) @(posedge clk);
      miscompares++;
      conclude();
   end

   // ==========
   // Main sequence
   initial begin
      logic [23:0] d;
      logic [3:0]  s;
      logic [11:0] a;
      int          g;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      rd_chk("ctrl", 8'h00, 32'h0);
      rd_chk("gain", 8'h04, 32'h3e8);
      rd_chk("unmapped", 8'h14, 32'h0);
      wr_reg(8'h04, 32'h1fff);
      rd_chk("gain_max", 8'h04, 32'hb22);
      // Enable low must swallow a write
      @(posedge clk);
      ce <= 1'b0;
      wr_reg(8'h04, 32'h10);
      ce <= 1'b1;
      rd_chk("gain_frozen", 8'h04, 32'hb22);
      for (int i = 0; i < 16; i++) begin
         g = int'(rnd() % (i[3] ? 5701 : 2851));
         wr_reg(8'h00, 32'((i % 8) << 4 | i[3] << 2 | 1));
         wr_reg(8'h04, 32'(g));
         rd_chk("gain", 8'h04, 32'(g));
         @(posedge clk);
         ext_in <= 16'(rnd());
         int_in <= $signed(16'(rnd())) >>> 1;
         repeat (2) @(posedge clk);
         #1;
         g = f_amp(i % 8, ext_in, int_in, g, i[3]);
         chk("amp", 32'(g), 32'(amp));
      end
      repeat (6) begin
         @(posedge clk);
         {st_in, seq_in} <= 9'(rnd());
         repeat (2) @(posedge clk);
         #1 chk("lim", 32'(|st_in[4:1]), 32'(lim_o));
         chk("pwr_busy", {st_in[5], st_in[0]}, {pwr_o, busy_o});
         chk("seq", 32'(seq_in), {sync_o, trg_o});
      end
      wr_reg(8'h00, 32'h1);
      wr_reg(8'h10, 32'h0);
      for (int j = 0; j < 7; j++) cmd(j, 1, j[0] ? 5 : 1);
      chk("out_on", 32'h1, 32'(out_o));
      wr_reg(8'h00, 32'h0);
      cmd(0, 0, 2);
      chk("out_kept", 32'h1, 32'(out_o));
      wr_reg(8'h00, 32'h1);
      cmd(0, 1, 2);
      for (int i = 0; i < 12; i++) begin
         d = i < 4 ? cor[i] : rnd();
         s = 4'(rnd());
         a = i == 0 ? 12'hfff : 12'(rnd());
         wave(1'b1, s, a, d);
         chk("refused", 32'h0, 32'(w_ref));
         wave(1'b0, s, a, 24'h0);
         chk("wave", 32'(f_clip(d)), 32'(w_q));
      end
      wave(1'b1, 4'h0, 12'h000, 24'h000005);
      cmd(1, 1, 2);
      wave(1'b1, 4'h0, 12'h000, 24'h000777);
      chk("refused", 32'h1, 32'(w_ref));
      wave(1'b0, 4'h0, 12'h000, 24'h0);
      chk("kept", 32'h5, 32'(w_q));
      wr_reg(8'h00, 32'h51);
      foreach (ns[k]) begin
         cmd(1, 1, 2);
         rises(1'b0, ns[k]);
         g = int'(ns[k] inside {[11:250]});
         chk("locked", 32'(g), 32'(locked));
         chk("out_sync", 32'(ns[k] >= 10), 32'(out_o));
         if (ns[k] <= 250) chk("period", 32'(ns[k]), 32'(per));
      end
      wr_reg(8'h00, 32'h53);
      rises(1'b1, 30);
      chk("line_lock", 32'h1, 32'(locked));
      rd_chk("period", 8'h0c, 32'd30);
      d = {18'h00000, 2'b01, st_in[0], |st_in[4:1], 1'b0, st_in[5]};
      rd_chk("stat", 8'h08, 32'(d));
      conclude();
   end
endmodule : tb_external_control_io
`default_nettype wire
